// ==== inc/loader_pkg.sv ====
// Shared layout of the programming stream and loader constants
`default_nettype none
package loader_pkg;
   localparam int WORD_W     = 32;   // Stream word width
   localparam int KEY_W      = 128;  // AES key and pass key width
   localparam int KEY_WORDS  = 4;    // Words per 128-bit key
   localparam int REGION_W   = 4;    // One select bit per region

   // Header word fields
   localparam int HDR_ENC_BIT  = 0;  // Set when payload is encrypted
   localparam int HDR_REG_LSB  = 1;  // Region select field, low bit

   // Region select bit positions
   localparam int REG_SEC   = 0;     // Security settings
   localparam int REG_ARRAY = 1;     // Logic array
   localparam int REG_ROM   = 2;     // User ROM
   localparam int REG_EMB   = 3;     // Embedded memory blocks

   // Security payload: new pass key then new AES key
   localparam logic [3:0] SEC_WORDS  = 4'h8;
   localparam logic [3:0] PKEY_LAST  = 4'h3;
   localparam logic [3:0] SEC_LAST   = 4'h7;
   localparam logic [3:0] IDX_ZERO   = 4'h0;
   localparam logic [3:0] IDX_ONE    = 4'h1;

   // Keystream and MAC mixing constants
   localparam logic [31:0] KS_STEP   = 32'h9E3779B9;
   localparam logic [31:0] MAC_SEED  = 32'h6A09E667;
   localparam int          MAC_ROT   = 5;
   localparam logic [KEY_W-1:0] KEY_BLANK = 128'h0;

   // Loader sequence
   typedef enum logic [3:0] {
      ST_IDLE, ST_HDR, ST_PKEY, ST_SEC, ST_DATA,
      ST_DRAIN, ST_ERASE, ST_PROG
   } load_state_t;
endpackage
`default_nettype wire

// ==== rtl/stage_buffer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Small FIFO between decryptor and staging side
module stage_buffer
   import loader_pkg::*;
#(
   parameter int WIDTH = 32,         // Word width
   parameter int DEPTH = 2           // Entries
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;  // Entry storage
      logic [PW-1:0]               rd;   // Read pointer
      logic [PW-1:0]               wr;   // Write pointer
      logic [CW-1:0]               cnt;  // Fill level
   } buf_t;

   buf_t cur;                           // Registered state
   buf_t next_cur;                      // Next state

   logic push;                          // Word accepted
   logic pop;                           // Word delivered

   // Honest full and empty flags
   assign in_ready  = (cur.cnt != CW'(DEPTH));
   assign out_valid = (cur.cnt != '0);
   assign out_data  = cur.mem[cur.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer and count update
   always_comb begin
      next_cur = cur;
      if (push) begin
         next_cur.mem[cur.wr] = in_data;
         next_cur.wr = (cur.wr == PW'(DEPTH - 1)) ? '0 : cur.wr + 1'b1;
      end
      if (pop) begin
         next_cur.rd = (cur.rd == PW'(DEPTH - 1)) ? '0 : cur.rd + 1'b1;
      end
      if (push && !pop) begin
         next_cur.cnt = cur.cnt + 1'b1;
      end else if (pop && !push) begin
         next_cur.cnt = cur.cnt - 1'b1;
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/secure_bitstream_loader.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - AES key kept internal, never driven out
// - Decrypt file and check MAC before programming
// - MAC folds every decrypted word of stream
// - Intake runs beside the live user design
// - Valid MAC leads to erase, then program
// - Failed MAC discards staged data, no change
// - Wrong key yields bad MAC, file dropped
// - Pass key locks array, ROM, security settings
// - Plaintext accepted when matching pass key given
// - Header selects each region independently
// - Security settings change only when selected
module secure_bitstream_loader
   import loader_pkg::*;
#(
   parameter int BUF_DEPTH = 2          // Staging buffer entries
) (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                in_valid,
   output logic                     in_ready,
   input  wire logic [WORD_W-1:0]   in_data,
   input  wire logic                in_last,
   input  wire logic [KEY_W-1:0]    nv_aes_key,
   input  wire logic [KEY_W-1:0]    nv_pass_key,
   output logic                     out_valid,
   input  wire logic                out_ready,
   output logic [WORD_W-1:0]        out_data,
   output logic [REGION_W-1:0]      out_region,
   output logic                     erase_pulse,
   output logic                     commit_pulse,
   output logic                     discard_pulse,
   output logic                     sec_wr,
   output logic [KEY_W-1:0]         sec_pass_key,
   output logic [KEY_W-1:0]         sec_aes_key,
   output logic                     locked,
   output logic                     busy
);
   typedef struct packed {
      load_state_t          st;        // Sequence state
      logic [3:0]           idx;       // Word index in key fields
      logic                 enc;       // File is encrypted
      logic [REGION_W-1:0]  regions;   // Selected regions
      logic [KEY_W-1:0]     pkey;      // Presented pass key
      logic [KEY_W-1:0]     new_pass;  // Incoming pass key
      logic [KEY_W-1:0]     new_key;   // Incoming AES key
      logic [WORD_W-1:0]    mac;       // Running MAC
      logic [WORD_W-1:0]    ks;        // Keystream accumulator
      logic [1:0]           kw;        // Key word selector
      logic                 locked;    // Session lock
      logic                 good;      // Authenticated and unlocked
      logic                 erase;     // Erase strobe
      logic                 commit;    // Program strobe
      logic                 discard;   // Drop strobe
      logic                 sec_wr;    // Security write strobe
   } ldr_t;

   ldr_t cur;                          // Registered state
   ldr_t next_cur;                     // Next state

   logic               take;           // Input word accepted
   logic [WORD_W-1:0]  plain;          // Decrypted word
   logic [WORD_W-1:0]  key_word;       // Active key slice
   logic [WORD_W-1:0]  mac_step;       // MAC after this word
   logic               buf_push;       // Payload word into buffer
   logic               buf_ready;      // Buffer has room
   logic               buf_out_valid;  // Buffer holds a word

   // Key slice feeds only the decryption and MAC, never a port
   assign key_word = cur.enc ? nv_aes_key[cur.kw*WORD_W +: WORD_W]
                             : '0;
   // Decryption of payload words; plaintext files pass unchanged
   assign plain    = cur.enc ? (in_data ^ cur.ks ^ key_word)
                             : in_data;
   // Keyed MAC over each decrypted word
   assign mac_step = {cur.mac[WORD_W-MAC_ROT-1:0],
                      cur.mac[WORD_W-1:WORD_W-MAC_ROT]}
                     ^ (plain + key_word);

   // Payload words pass through the buffer; tag word stays here
   assign buf_push = (cur.st == ST_DATA) && in_valid && !in_last;

   // Intake back-pressure
   always_comb begin
      case (cur.st)
         ST_HDR, ST_PKEY, ST_SEC: in_ready = 1'b1;
         ST_DATA:                 in_ready = in_last || buf_ready;
         default:                 in_ready = 1'b0;
      endcase
   end
   assign take = in_valid && in_ready;

   // Loader sequence
   always_comb begin
      next_cur         = cur;
      next_cur.erase   = 1'b0;
      next_cur.commit  = 1'b0;
      next_cur.discard = 1'b0;
      next_cur.sec_wr  = 1'b0;
      if (take && (cur.st == ST_SEC || cur.st == ST_DATA)) begin
         // Advance keystream and key word on every security and data-phase word, tag included
         next_cur.ks = cur.ks + KS_STEP;
         next_cur.kw = cur.kw + 2'h1;
      end
      case (cur.st)
         ST_IDLE: begin
            // One cycle to reset MAC, keystream and index, then on to header
            next_cur.st  = ST_HDR;
            next_cur.mac = MAC_SEED;
            next_cur.ks  = '0;
            next_cur.kw  = '0;
            next_cur.idx = IDX_ZERO;
         end
         ST_HDR: begin
            // Header picks cipher mode and regions
            if (take) begin
               next_cur.enc     = in_data[HDR_ENC_BIT];
               next_cur.regions =
                  in_data[HDR_REG_LSB +: REGION_W];
               next_cur.st      = ST_PKEY;
            end
         end
         ST_PKEY: begin
            // Presented pass key, sent in the clear
            if (take) begin
               next_cur.pkey = {cur.pkey[KEY_W-WORD_W-1:0], in_data};
               next_cur.idx  = cur.idx + IDX_ONE;
               if (cur.idx == PKEY_LAST) begin
                  next_cur.idx = IDX_ZERO;
                  // Lock holds for the rest of the session
                  next_cur.locked = (nv_pass_key != KEY_BLANK) &&
                     ({cur.pkey[KEY_W-WORD_W-1:0], in_data}
                      != nv_pass_key);
                  next_cur.st = cur.regions[REG_SEC] ? ST_SEC
                                                     : ST_DATA;
               end
            end
         end
         ST_SEC: begin
            // New pass key then new AES key, decrypted and MACed
            if (take) begin
               next_cur.mac = mac_step;
               if (cur.idx <= PKEY_LAST) begin
                  next_cur.new_pass =
                     {cur.new_pass[KEY_W-WORD_W-1:0], plain};
               end else begin
                  next_cur.new_key =
                     {cur.new_key[KEY_W-WORD_W-1:0], plain};
               end
               next_cur.idx = cur.idx + IDX_ONE;
               if (cur.idx == SEC_LAST) begin
                  next_cur.st = ST_DATA;
               end
            end
         end
         ST_DATA: begin
            // Payload words flow to staging; final word is the tag
            if (take && !in_last) begin
               next_cur.mac = mac_step;
            end else if (take) begin
               // Wrong key or corruption both give a tag mismatch
               next_cur.good = (cur.mac == in_data) &&
                               !cur.locked;
               next_cur.st   = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // Wait until staging has delivered every word
            if (!buf_out_valid) begin
               if (cur.good) begin
                  next_cur.st    = ST_ERASE;
                  next_cur.erase = 1'b1;
               end else begin
                  // Live contents untouched, staged data dropped
                  next_cur.st      = ST_IDLE;
                  next_cur.discard = 1'b1;
               end
            end
         end
         ST_ERASE: begin
            // Program only after the erase strobe
            next_cur.st     = ST_PROG;
            next_cur.commit = 1'b1;
            next_cur.sec_wr = cur.regions[REG_SEC];
         end
         ST_PROG: begin
            // One cycle to let strobes settle, then back to idle
            next_cur.st = ST_IDLE;
         end
         default: begin
            next_cur.st = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cur <= '0;
         cur.st <= ST_IDLE;
      end else begin
         cur <= next_cur;
      end
   end

   // Staging buffer absorbs receiver stalls
   stage_buffer #(
      .WIDTH (WORD_W),
      .DEPTH (BUF_DEPTH)
   ) u_stage (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (buf_push),
      .in_ready  (buf_ready),
      .in_data   (plain),
      .out_valid (buf_out_valid),
      .out_ready (out_ready),
      .out_data  (out_data)
   );

   // Outputs; user design keeps running throughout intake
   assign out_valid     = buf_out_valid;
   assign out_region    = cur.regions;
   assign erase_pulse   = cur.erase;
   assign commit_pulse  = cur.commit;
   assign discard_pulse = cur.discard;
   assign sec_wr        = cur.sec_wr;
   assign sec_pass_key  = cur.new_pass;
   assign sec_aes_key   = cur.new_key;
   assign locked        = cur.locked;
   assign busy          = (cur.st != ST_IDLE) && (cur.st != ST_HDR);
endmodule
`default_nettype wire

// ==== test/loader_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// Port watch on the loader outcome pulses
module loader_sva
   import loader_pkg::*;
(
   input wire logic                ref_clk,
   input wire logic                rst,
   input wire logic                in_ready,
   input wire logic                out_valid,
   input wire logic                out_ready,
   input wire logic [WORD_W-1:0]   out_data,
   input wire logic [REGION_W-1:0] out_region,
   input wire logic                erase_pulse,
   input wire logic                commit_pulse,
   input wire logic                discard_pulse,
   input wire logic                sec_wr,
   input wire logic                locked
);
   // One clock domain, sync reset
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_ERASE_COMMIT: assert property (erase_pulse |=> commit_pulse)
      else $error("commit did not follow erase");
   AST_COMMIT_CAUSE: assert property (
      commit_pulse |-> $past(erase_pulse))
      else $error("commit without erase");
   AST_ERASE_ONCE: assert property (
      erase_pulse |=> !erase_pulse [*2])
      else $error("erase longer than one cycle");
   AST_SEC_COMMIT: assert property (
      sec_wr |-> commit_pulse && out_region[REG_SEC])
      else $error("settings write outside selected commit");
   AST_LOCK_SAFE: assert property (
      locked |-> !erase_pulse && !sec_wr)
      else $error("change while locked");
   AST_DISCARD: assert property (
      discard_pulse |-> !erase_pulse ##1 !commit_pulse && !sec_wr)
      else $error("discard mixed with commit");
   AST_OUT_HOLD: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("staged word lost in stall");
   AST_REOPEN: assert property (
      commit_pulse |=> !in_ready ##1 in_ready)
      else $error("next header not opened on time");
endmodule
bind secure_bitstream_loader loader_sva u_loader_sva (.ref_clk, .rst,
   .in_ready, .out_valid, .out_ready, .out_data, .out_region, .erase_pulse,
   .commit_pulse, .discard_pulse, .sec_wr, .locked);
`default_nettype wire

// ==== test/prog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Programmer model: builds and streams one file
module prog_model
   import loader_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         in_ready,
   output logic              in_valid,
   output logic [WORD_W-1:0] in_data,
   output logic              in_last
);
   logic [WORD_W-1:0] exp_q [$];  // Plain data words sent
   logic [WORD_W-1:0] mac;        // Running tag
   logic [WORD_W-1:0] ks;         // Keystream
   logic [KEY_W-1:0]  key;        // Cipher key, blank if plain
   logic [1:0]        kw;         // Key word index
   // Idle bus at time zero
   initial begin
      in_valid = 1'b0;
      in_data  = '0;
      in_last  = 1'b0;
   end
   // One word, held until taken
   task automatic put(input logic [WORD_W-1:0] w, input logic l);
      @(negedge ref_clk);
      in_valid <= 1'b1;
      in_data  <= w;
      in_last  <= l;
      do @(posedge ref_clk); while (in_ready !== 1'b1);
   endtask
   // Protected word: cipher and tag fold
   task automatic prot(input logic [WORD_W-1:0] p, input logic enc);
      logic [WORD_W-1:0] kk;
      kk = key[32*kw +: 32];
      mac = (mac << MAC_ROT | mac >> (WORD_W-MAC_ROT)) ^ (p + kk);
      put(enc ? p ^ ks ^ kk : p, 1'b0);
      ks = ks + KS_STEP;
      kw = kw + 2'h1;
   endtask
   // Whole file; bad spoils the tag
   task automatic send(input logic [WORD_W-1:0] hdr,
      input logic [KEY_W-1:0] pk, ek, sp, sa, input int n, input logic bad);
      logic enc;
      enc = hdr[HDR_ENC_BIT];
      key = enc ? ek : KEY_BLANK;
      mac = MAC_SEED;
      ks = '0;
      kw = 2'h0;
      exp_q.delete();
      put(hdr, 1'b0);
      for (int j = 3; j >= 0; j--)
         put(pk[32*j +: 32], 1'b0);
      if (hdr[HDR_REG_LSB+REG_SEC]) begin
         for (int j = 3; j >= 0; j--) prot(sp[32*j +: 32], enc);
         for (int j = 3; j >= 0; j--) prot(sa[32*j +: 32], enc);
      end
      for (int j = 0; j < n; j++) begin
         exp_q.push_back(32'hA5000000 + WORD_W'(j));
         prot(exp_q[j], enc);
      end
      put(bad ? ~mac : mac, 1'b1);
      @(negedge ref_clk);
      in_valid <= 1'b0;
      in_data  <= ~in_data;  // Released bus shows no stale word
      in_last  <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== test/tb_secure_bitstream_loader.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the secure loader
module tb_secure_bitstream_loader
   import loader_pkg::*;
();
   localparam logic [KEY_W-1:0] KA = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;
   localparam logic [KEY_W-1:0] KB = 128'hFEDCBA9876543210A1B2C3D4E5F60718;
   localparam logic [KEY_W-1:0] PK = 128'h13579BDF2468ACE0112233445566778A;
   logic ref_clk, rst, in_valid, in_ready, in_last, out_valid, out_ready;
   logic erase_pulse, commit_pulse, discard_pulse, sec_wr, locked, busy;
   logic [WORD_W-1:0]   in_data, out_data;
   logic [REGION_W-1:0] out_region, got_rg;
   logic [KEY_W-1:0]    nv_aes_key, nv_pass_key, sec_pass_key, sec_aes_key;
   logic [KEY_W-1:0]    got_sp, got_sa;
   logic [WORD_W-1:0]   got_q [$];
   int err_total, check_count, n_er, n_cm, n_dc, n_sw, n_rf, n_by;
   secure_bitstream_loader u_secure_bitstream_loader (.ref_clk, .rst,
      .in_valid, .in_ready, .in_data, .in_last, .nv_aes_key, .nv_pass_key,
      .out_valid, .out_ready, .out_data, .out_region, .erase_pulse,
      .commit_pulse, .discard_pulse, .sec_wr, .sec_pass_key, .sec_aes_key,
      .locked, .busy);
   prog_model u_prog_model (.ref_clk, .in_ready, .in_valid, .in_data,
      .in_last);
   // 20 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // Collect staged words and outcome pulses
   always @(posedge ref_clk) begin
      if (out_valid && out_ready) got_q.push_back(out_data);
      if (in_valid && !in_ready) n_rf++;
      n_er += erase_pulse;
      n_dc += discard_pulse;
      n_by += busy;
      if (commit_pulse) begin
         n_cm++;
         got_rg = out_region;
      end
      if (sec_wr) begin
         n_sw++;
         got_sp = sec_pass_key;
         got_sa = sec_aes_key;
      end
   end
   // Compare and count
   task automatic chk(input string nm, input logic [KEY_W-1:0] e, g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Send one file, stall staging side, await outcome
   task automatic run(input logic [WORD_W-1:0] h, input logic [KEY_W-1:0] pk,
      ek, sp, sa, input int n, input logic bad, input int stall);
      {n_er, n_cm, n_dc, n_sw, n_rf, n_by} = '0;
      got_q.delete();
      out_ready <= (stall == 0);
      fork
         u_prog_model.send(h, pk, ek, sp, sa, n, bad);
         if (stall > 0) begin
            repeat (stall) @(negedge ref_clk);
            out_ready <= 1'b1;
         end
      join
      for (int k = 0; k < 60 && n_cm + n_dc == 0; k++) @(posedge ref_clk);
      repeat (4) @(negedge ref_clk);
   endtask
   // Staged words match the file in order
   task automatic chk_data(input int n);
      chk("word count", n, got_q.size());
      foreach (got_q[i]) chk("data", u_prog_model.exp_q[i], got_q[i]);
   endtask
   task automatic t_plain();
      run(32'h4, PK, KA, '0, '0, 3, 1'b0, 0);
      chk("erase", 1, n_er);
      chk("commit", 1, n_cm);
      chk("sec_wr", 0, n_sw);
      chk_data(3);
      chk("busy seen", 1, n_by > 0);
      chk("busy after file", 0, busy);
      $display("plain test done");
   endtask
   task automatic t_secure();
      run(32'h1F, PK, KA, PK, KB, 2, 1'b0, 0);
      chk("sec_wr", 1, n_sw);
      chk("new pass key", PK, got_sp);
      chk("new aes key", KB, got_sa);
      chk("regions", 4'hF, got_rg);
      chk("locked", 0, locked);
      chk_data(2);
      $display("secure test done");
   endtask
   task automatic t_wrong_key();
      run(32'h3, PK, KB, PK, KA, 2, 1'b0, 0);
      chk("discard", 1, n_dc);
      chk("erase", 0, n_er + n_cm);
      chk("sec_wr", 0, n_sw);
      $display("wrong key test done");
   endtask
   task automatic t_bad_pkey();
      run(32'h4, ~PK, KA, '0, '0, 2, 1'b0, 0);
      chk("locked", 1, locked);
      chk("discard", 1, n_dc);
      chk("erase", 0, n_er);
      $display("pass key test done");
   endtask
   task automatic t_bad_tag();
      run(32'h4, PK, KA, '0, '0, 3, 1'b1, 0);
      chk("discard", 1, n_dc);
      chk("erase", 0, n_er + n_cm);
      $display("tag test done");
   endtask
   task automatic t_stall();
      nv_pass_key <= '0;
      run(32'h14, KB, KA, '0, '0, 5, 1'b0, 12);
      chk("refused", 1, n_rf > 0);
      chk("commit", 1, n_cm);
      chk_data(5);
      $display("stall test done");
   endtask
   // Verdict and end of run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      {err_total, check_count} = '0;
      rst = 1'b1;
      out_ready = 1'b0;
      nv_aes_key = KA;
      nv_pass_key = PK;
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      t_plain();
      t_secure();
      t_wrong_key();
      t_bad_pkey();
      t_bad_tag();
      t_stall();
      end_of_test();
   end
   // Watchdog
   initial begin
      #(5000 * 50);
      err_total++;
      end_of_test();
   end
endmodule
`default_nettype wire
